// file: design/conv_pkg.sv
// Package: shared types and constants for the code conversion and direct I/O unit
package conv_pkg;
    // ------------------------------------------------------------------
    // Sizes and limits
    // ------------------------------------------------------------------
    localparam int          WORD_W        = 16;
    localparam int          MAX_CHARS     = 16;          // Characters per string execution
    localparam int          DEST_WORDS    = MAX_CHARS / 2;
    localparam int          MAX_REFRESH   = 32;          // Largest refresh run
    localparam int          IO_WORDS      = 64;          // Word register space
    localparam logic [15:0] BCD_MAX_BIN   = 16'd9999;
    localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
    localparam logic [15:0] WORD_RST      = 16'h0000;

    // ------------------------------------------------------------------
    // Operation select
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_STRING  = 2'b00,
        OP_DEC2BIN = 2'b01,
        OP_BIN2DEC = 2'b10,
        OP_REFRESH = 2'b11
    } op_t;

    // Request bundle from the sequencer
    typedef struct packed {
        logic        enable;
        op_t         op;
        logic [15:0] source;       // Source word for the number conversions
        logic [4:0]  char_count;   // Characters to pack, 0..16
        logic [5:0]  start_reg;    // First word register of refresh run
        logic [5:0]  reg_count;    // Refresh run length, 1..32
    } req_t;

    // Result bundle back to the sequencer
    typedef struct packed {
        logic        done;         // Output of the operation
        logic        write;        // Destination word written
        logic [15:0] data;         // Destination word value
    } res_t;
endpackage

// file: design/conv_unit.sv
// Module: code conversion and direct I/O execution unit
// Functional notes
// - String packing puts the first character of each pair in bits 7..0 and the next in 15..8.
// - Only bytes for converted characters are written; later destination words keep data.
// - At most sixteen characters are taken per execution into the destination word table.
// - Decimal-to-binary reads four BCD digits, writes the binary value and sets the output.
// - A nibble above 9 blocks the write, keeps the output off and sets the error flag.
// - A constant decimal source lies in the span 0000 to 9999 packed decimal.
// - Binary-to-decimal turns 0..9999 into four packed BCD digits and sets the output.
// - A negative source or one above 9999 blocks the write, output off, error flag set.
// - The error flag stays set until the user program clears it.
// - Refresh updates a run of 1 to 32 word registers at once, not at scan end.
// - Input words load from physical inputs; output words drive physical outputs.
// - Only on-board and expansion points are refreshed; option card points are skipped.
`timescale 1ns/1ps

module conv_unit
    import conv_pkg::*;
#(
    parameter int NUM_WORDS = conv_pkg::IO_WORDS
) (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    NRST,
    // Sequencer request and result
    input  wire conv_pkg::req_t          REQ,
    input  wire logic [127:0]            CHARS,         // Character codes, first in bits 7..0
    output conv_pkg::res_t               RES,
    output logic [127:0]                 STR_DEST,      // Destination word table
    // Error flag and its clear from the user program
    input  wire logic                    ERR_CLEAR,
    output logic                         INSTRUCTION_ERROR_FLAG,
    // Physical I/O
    input  wire logic [NUM_WORDS*16-1:0] INPUT_PINS,
    input  wire logic [NUM_WORDS-1:0]    WORD_IS_OUTPUT,  // Word direction map
    input  wire logic [NUM_WORDS-1:0]    WORD_ON_OPTION,  // Word served by an option card
    input  wire logic [NUM_WORDS*16-1:0] OUTPUT_WORD_REGISTER_IN,
    output logic [NUM_WORDS*16-1:0]      INPUT_WORD_REGISTER,
    output logic [NUM_WORDS*16-1:0]      OUTPUT_PINS
);
    import conv_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_WORDS < 1 || NUM_WORDS > IO_WORDS) begin : g_bad_words
        $error("NUM_WORDS out of range");
    end

    // ------------------------------------------------------------------
    // Conversion helpers
    // ------------------------------------------------------------------
    // True when every nibble is a decimal digit
    function automatic logic bcd_ok(input logic [15:0] v);
        bcd_ok = (v[3:0] <= BCD_DIGIT_MAX) && (v[7:4] <= BCD_DIGIT_MAX)
              && (v[11:8] <= BCD_DIGIT_MAX) && (v[15:12] <= BCD_DIGIT_MAX);
    endfunction

    function automatic logic [15:0] bcd_to_bin(input logic [15:0] v);
        logic [15:0] acc;
        acc = 16'(v[15:12]) * 16'd1000 + 16'(v[11:8]) * 16'd100
            + 16'(v[7:4]) * 16'd10 + 16'(v[3:0]);
        bcd_to_bin = acc;
    endfunction

    function automatic logic [15:0] bin_to_bcd(input logic [15:0] v);
        logic [15:0] r;
        r = {4'((v / 16'd1000) % 16'd10), 4'((v / 16'd100) % 16'd10),
             4'((v / 16'd10) % 16'd10), 4'(v % 16'd10)};
        bin_to_bcd = r;
    endfunction

    // ------------------------------------------------------------------
    // Execution decode
    // ------------------------------------------------------------------
    logic        run;
    logic        dec_good;
    logic        bin_good;
    logic [4:0]  nchars;
    logic [6:0]  last_reg;
    assign run      = REQ.enable;
    assign dec_good = bcd_ok(REQ.source);
    assign bin_good = !REQ.source[15] && (REQ.source <= BCD_MAX_BIN);
    // Counts above sixteen are clipped rather than refused
    assign nchars   = (REQ.char_count > 5'(MAX_CHARS)) ? 5'(MAX_CHARS)
                    : REQ.char_count;
    // One bit wider so a run near the top of the word space cannot wrap
    assign last_reg = 7'(REQ.start_reg) + 7'(REQ.reg_count);

    // ------------------------------------------------------------------
    // Result word and operation output
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RES <= '0;
        end else begin
            RES <= '0;
            if (run) begin
                case (REQ.op)
                    OP_DEC2BIN: begin
                        if (dec_good) begin
                            RES.done  <= 1'b1;
                            RES.write <= 1'b1;
                            RES.data  <= bcd_to_bin(REQ.source);
                        end
                    end
                    OP_BIN2DEC: begin
                        if (bin_good) begin
                            RES.done  <= 1'b1;
                            RES.write <= 1'b1;
                            RES.data  <= bin_to_bcd(REQ.source);
                        end
                    end
                    OP_STRING:  RES.done <= 1'b1;
                    OP_REFRESH: RES.done <= (REQ.reg_count != 6'd0)
                                         && (REQ.reg_count <= 6'(MAX_REFRESH));
                    default:    RES.done <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // String packing, byte writes only for converted characters
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            STR_DEST <= '0;
        end else if (run && REQ.op == OP_STRING) begin
            for (int i = 0; i < MAX_CHARS; i++) begin
                // Byte i lands at word i/2, low byte first
                if (5'(i) < nchars) begin
                    STR_DEST[i*8 +: 8] <= CHARS[i*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Error flag: set beats clear so no failure is lost
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            INSTRUCTION_ERROR_FLAG <= 1'b0;
        end else if (run && ((REQ.op == OP_DEC2BIN && !dec_good)
                          || (REQ.op == OP_BIN2DEC && !bin_good))) begin
            INSTRUCTION_ERROR_FLAG <= 1'b1;
        end else if (ERR_CLEAR) begin
            INSTRUCTION_ERROR_FLAG <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchroniser; first stage is read only by the second
    // ------------------------------------------------------------------
    logic [NUM_WORDS*16-1:0] pin_meta_r;
    logic [NUM_WORDS*16-1:0] pin_sync_r;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= INPUT_PINS;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Immediate refresh of the word run
    // ------------------------------------------------------------------
    logic refresh_go;
    assign refresh_go = run && REQ.op == OP_REFRESH && REQ.reg_count != 6'd0
                     && REQ.reg_count <= 6'(MAX_REFRESH);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            INPUT_WORD_REGISTER <= '0;
            OUTPUT_PINS         <= '0;
        end else if (refresh_go) begin
            for (int w = 0; w < NUM_WORDS; w++) begin
                // Option card words are never touched here
                if (7'(w) >= 7'(REQ.start_reg) && 7'(w) < last_reg
                    && !WORD_ON_OPTION[w]) begin
                    if (WORD_IS_OUTPUT[w]) begin
                        OUTPUT_PINS[w*16 +: 16] <= OUTPUT_WORD_REGISTER_IN[w*16 +: 16];
                    end else begin
                        INPUT_WORD_REGISTER[w*16 +: 16] <= pin_sync_r[w*16 +: 16];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_idle_out_off: assert property (@(posedge CLK) disable iff (!NRST)
        !$past(REQ.enable) |-> !RES.done)
        else $error("Output on without enable");
    chk_bcd_bad_err: assert property (@(posedge CLK) disable iff (!NRST)
        (run && REQ.op == OP_DEC2BIN && !bcd_ok(REQ.source))
        |=> (INSTRUCTION_ERROR_FLAG && !RES.done && !RES.write))
        else $error("Bad BCD not flagged");
    chk_bcd_good_val: assert property (@(posedge CLK) disable iff (!NRST)
        (run && REQ.op == OP_DEC2BIN && REQ.source == 16'h1234)
        |=> (RES.done && RES.data == 16'd1234))
        else $error("BCD conversion wrong");
    chk_bin_range_err: assert property (@(posedge CLK) disable iff (!NRST)
        (run && REQ.op == OP_BIN2DEC && REQ.source > 16'd9999)
        |=> (INSTRUCTION_ERROR_FLAG && !RES.write))
        else $error("Range error not flagged");
    chk_bin_good_val: assert property (@(posedge CLK) disable iff (!NRST)
        (run && REQ.op == OP_BIN2DEC && REQ.source == 16'd5432)
        |=> (RES.done && RES.data == 16'h5432))
        else $error("Binary conversion wrong");
    chk_err_sticky: assert property (@(posedge CLK) disable iff (!NRST)
        (INSTRUCTION_ERROR_FLAG && !ERR_CLEAR) |=> INSTRUCTION_ERROR_FLAG)
        else $error("Error flag dropped");
    chk_str_low_byte: assert property (@(posedge CLK) disable iff (!NRST)
        (run && REQ.op == OP_STRING && REQ.char_count != 5'd0)
        |=> STR_DEST[7:0] == $past(CHARS[7:0]))
        else $error("First character misplaced");
    chk_str_odd_keep: assert property (@(posedge CLK) disable iff (!NRST)
        (run && REQ.op == OP_STRING && REQ.char_count == 5'd1)
        |=> $stable(STR_DEST[15:8]))
        else $error("High byte overwritten");
    chk_refresh_word0: assert property (@(posedge CLK) disable iff (!NRST)
        (refresh_go && REQ.start_reg == 6'd0 && !WORD_IS_OUTPUT[0] && !WORD_ON_OPTION[0])
        |=> INPUT_WORD_REGISTER[15:0] == $past(pin_sync_r[15:0]))
        else $error("Input word not refreshed");
endmodule

// file: tb/io_circuits.sv
// Physical I/O circuits model: input levels and word maps seen by the refresh logic
`timescale 1ns/1ps

module io_circuits #(
    parameter int NUM_WORDS = 64
) (
    // Wiring toward the unit
    output logic [NUM_WORDS*16-1:0] INPUT_PINS,
    output logic [NUM_WORDS-1:0]    WORD_IS_OUTPUT,
    output logic [NUM_WORDS-1:0]    WORD_ON_OPTION
);
    // Static levels, so the two-flop synchroniser never sees a change mid-test
    always_comb begin
        for (int k = 0; k < NUM_WORDS; k++) begin
            INPUT_PINS[16*k +: 16] = 16'ha500 + 16'(k);
            WORD_IS_OUTPUT[k]      = k[0];
            WORD_ON_OPTION[k]      = (k == 2);
        end
    end
endmodule

// file: tb/code_conversion_and_direct_io_test.sv
// Self-checking bench for the code conversion and direct I/O unit
`timescale 1ns/1ps

module code_conversion_and_direct_io_test;
    import conv_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int NW = IO_WORDS;
    logic            CLK       = 1'b0;
    logic            NRST      = 1'b0;
    req_t            REQ       = '0;
    logic [127:0]    CHARS     = '0;
    logic            ERR_CLEAR = 1'b0;
    logic [NW*16-1:0] owr_in   = '0;
    res_t            RES;
    logic [127:0]    STR_DEST;
    logic            FLAG;
    logic [NW*16-1:0] pins, iwr, opins;
    logic [NW-1:0]   is_out, on_opt;
    logic [15:0]     exp_i [NW];
    logic [15:0]     exp_o [NW];
    int              failures   = 0;
    int              num_checks = 0;

    // Clock at 25 MHz
    always #20 CLK = ~CLK;

    conv_unit conv_unit_i (.CLK(CLK), .NRST(NRST), .REQ(REQ), .CHARS(CHARS), .RES(RES),
        .STR_DEST(STR_DEST), .ERR_CLEAR(ERR_CLEAR), .INSTRUCTION_ERROR_FLAG(FLAG),
        .INPUT_PINS(pins), .WORD_IS_OUTPUT(is_out), .WORD_ON_OPTION(on_opt),
        .OUTPUT_WORD_REGISTER_IN(owr_in), .INPUT_WORD_REGISTER(iwr), .OUTPUT_PINS(opins));
    io_circuits #(.NUM_WORDS(NW)) io_circuits_i (.INPUT_PINS(pins),
        .WORD_IS_OUTPUT(is_out), .WORD_ON_OPTION(on_opt));

    // ------------------------------------------------------------
    // Compare, drive and closing tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_res(input logic done, input logic [15:0] data);
        check_word({15'h0000, RES.done}, {15'h0000, done});
        if (done === 1'b1) check_word(RES.data, data);
    endtask

    // Enable stays high between calls, so back-to-back requests are legal
    task automatic issue(input op_t op, input logic [15:0] src, input logic [5:0] n);
        REQ.enable     = 1'b1;
        REQ.op         = op;
        REQ.source     = src;
        REQ.char_count = n[4:0];
        REQ.reg_count  = n;
        @(posedge CLK);
        @(negedge CLK);
    endtask

    task automatic idle(input string name);
        REQ.enable = 1'b0;
        @(negedge CLK);
        check_word({15'h0000, RES.done}, 16'h0000);
        $display("Test %s finished", name);
    endtask

    // One cycle of clear from the user program, then the flag must be low
    task automatic clear_flag;
        ERR_CLEAR = 1'b1;
        @(negedge CLK);
        ERR_CLEAR = 1'b0;
        check_word({15'h0000, FLAG}, 16'h0000);
    endtask

    task automatic stop_test;
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_string;
        for (int i = 0; i < 16; i++) CHARS[8*i +: 8] = 8'h41 + 8'(i);
        issue(OP_STRING, 16'h0000, 6'd16);
        for (int k = 0; k < 8; k++)
            check_word(STR_DEST[16*k +: 16], {8'h42 + 8'(2*k), 8'h41 + 8'(2*k)});
        for (int i = 0; i < 16; i++) CHARS[8*i +: 8] = 8'h61 + 8'(i);
        issue(OP_STRING, 16'h0000, 6'd3);
        check_res(1'b1, 16'h0000);
        check_word(STR_DEST[15:0], 16'h6261);
        check_word(STR_DEST[31:16], 16'h4463);
        check_word(STR_DEST[127:112], 16'h504f);
        issue(OP_STRING, 16'h0000, 6'd31);
        check_word(STR_DEST[127:112], 16'h706f);
        CHARS[7:0] = 8'h7a;
        issue(OP_STRING, 16'h0000, 6'd1);
        check_word(STR_DEST[15:0], 16'h627a);
        idle("string");
    endtask

    task automatic test_dec2bin;
        logic [15:0] bad [4] = '{16'ha000, 16'h0f00, 16'h00b0, 16'h000c};
        issue(OP_DEC2BIN, 16'h1234, 6'd0);
        check_res(1'b1, 16'd1234);
        check_word({15'h0000, RES.write}, 16'h0001);
        issue(OP_DEC2BIN, 16'h9999, 6'd0);
        check_res(1'b1, 16'd9999);
        check_word({15'h0000, FLAG}, 16'h0000);
        for (int j = 0; j < 4; j++) begin
            issue(OP_DEC2BIN, bad[j], 6'd0);
            check_res(1'b0, 16'h0000);
            check_word({15'h0000, RES.write}, 16'h0000);
            check_word({15'h0000, FLAG}, 16'h0001);
        end
        // A failure in the same cycle as a clear must still leave the flag set
        ERR_CLEAR = 1'b1;
        issue(OP_DEC2BIN, 16'h13a6, 6'd0);
        ERR_CLEAR = 1'b0;
        check_word({15'h0000, FLAG}, 16'h0001);
        issue(OP_DEC2BIN, 16'h0000, 6'd0);
        check_res(1'b1, 16'h0000);
        check_word({15'h0000, FLAG}, 16'h0001);
        idle("dec2bin");
        clear_flag();
    endtask

    task automatic test_bin2dec;
        issue(OP_BIN2DEC, 16'd5432, 6'd0);
        check_res(1'b1, 16'h5432);
        issue(OP_BIN2DEC, 16'd9999, 6'd0);
        check_res(1'b1, 16'h9999);
        issue(OP_BIN2DEC, 16'd0, 6'd0);
        check_res(1'b1, 16'h0000);
        check_word({15'h0000, FLAG}, 16'h0000);
        issue(OP_BIN2DEC, 16'd10000, 6'd0);
        check_res(1'b0, 16'h0000);
        check_word({15'h0000, FLAG}, 16'h0001);
        issue(OP_BIN2DEC, 16'hffff, 6'd0);
        check_res(1'b0, 16'h0000);
        check_word({15'h0000, FLAG}, 16'h0001);
        idle("bin2dec");
        clear_flag();
    endtask

    // Refresh a run and compare every word against the kept expectation
    task automatic refresh_chk(input logic [5:0] start, input logic [5:0] n, input logic ok);
        REQ.start_reg = start;
        issue(OP_REFRESH, 16'h0000, n);
        check_res(ok, 16'h0000);
        for (int k = 0; k < NW; k++) begin
            if (ok && k >= start && k < start + n && !on_opt[k]) begin
                if (is_out[k]) exp_o[k] = owr_in[16*k +: 16];
                else exp_i[k] = 16'ha500 + 16'(k);
            end
            check_word(iwr[16*k +: 16], exp_i[k]);
            check_word(opins[16*k +: 16], exp_o[k]);
        end
    endtask

    // Refresh is only requested from one program context here
    task automatic test_refresh;
        for (int k = 0; k < NW; k++) begin
            owr_in[16*k +: 16] = 16'h1100 + 16'(k);
            exp_i[k] = 16'h0000;
            exp_o[k] = 16'h0000;
        end
        refresh_chk(6'd0, 6'd4, 1'b1);
        refresh_chk(6'd0, 6'd0, 1'b0);
        refresh_chk(6'd0, 6'd33, 1'b0);
        refresh_chk(6'd1, 6'd32, 1'b1);
        refresh_chk(6'd40, 6'd30, 1'b1);
        check_word({15'h0000, FLAG}, 16'h0000);
        idle("refresh");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge CLK);
        NRST = 1'b1;
        test_string();
        test_dec2bin();
        test_bin2dec();
        test_refresh();
        stop_test();
    end

    // Whole run is well under 100 cycles; allow a wide margin
    initial begin
        #(40 * 2000);
        failures++;
        stop_test();
    end
endmodule
